/* design/dcp_consts.svh */
// register offsets, field positions and reset values of the pwm mode block
// assumes byte addressing on a 32-bit apb bus
`ifndef DCP_CONSTS_SVH
`define DCP_CONSTS_SVH
`define DCP_OFS_BUF_MODE     12'h000
`define DCP_OFS_FUNC_CTRL    12'h004
`define DCP_OFS_CUTOFF_SEL   12'h008
`define DCP_OFS_OUT_DISABLE  12'h00c
`define DCP_OFS_STATUS       12'h010
`define DCP_BUF_MODE_MASK    8'hf1
`define DCP_FUNC_CTRL_MASK   8'hcf
`define DCP_RST_BUF_MODE     8'h00
`define DCP_RST_FUNC_CTRL    8'h80
`define DCP_RST_CUTOFF_SEL   8'h00
`define DCP_RST_OUT_DISABLE  8'hff
`define DCP_BIT_SYNC         0
`define DCP_BIT_GRP0_C       4
`define DCP_BIT_GRP0_D       5
`define DCP_BIT_GRP1_C       6
`define DCP_BIT_GRP1_D       7
`define DCP_BIT_PWM_THREE_SELECT         7
`define DCP_BIT_A0_CUT_LO    6
`define DCP_BIT_B0_CUT_LO    4
`endif

/* design/dcp_pkg.sv */
// types of the pwm mode block
// assumes dcp_consts.svh holds the numbers
package dcp_pkg;
   typedef enum logic [3:0] {
      DCP_MODE_TIMER  = 4'h1,
      DCP_MODE_PWM_THREE_SELECT   = 4'h2,
      DCP_MODE_RSYNC  = 4'h4,
      DCP_MODE_COMPL  = 4'h8
   } dcp_mode_e;
   typedef enum logic [1:0] {
      DCP_CUT_OFF  = 2'h0,
      DCP_CUT_HIZ  = 2'h1,
      DCP_CUT_LOW  = 2'h2,
      DCP_CUT_HIGH = 2'h3
   } dcp_cut_e;
   typedef struct packed {
      logic [7:0]  buf_mode;
      logic [7:0]  func_ctrl;
      logic [7:0]  cutoff_sel;
      logic [7:0]  out_disable;
      logic [31:0] prdata;
      logic [3:0]  xfer_grp;
      logic [1:0]  pin_val;
      logic [1:0]  pin_oe_n;
   } dcp_state_s;
endpackage

/* design/dcp_pwm_mode_cfg.sv */
// configuration logic of a two-counter pwm timer pair
// assumes counter, compare and waveform logic outside, apb master on clk_sys
`include "dcp_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module dcp_pwm_mode_cfg (
   // clock, reset, enable
   input  wire  logic        clk_sys,
   input  wire  logic        rst_n,
   input  wire  logic        clk_en,
   // apb slave
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [11:0] paddr,
   input  wire  logic [31:0] pwdata,
   input  wire  logic [3:0]  pstrb,
   output logic              pready,
   output logic              pslverr,
   output logic [31:0]       prdata,
   // counter events, same clock
   input  wire  logic        cnt1_underflow,
   input  wire  logic        cnt0_match_a,
   input  wire  logic        cnt_running,
   // timer waveform levels for the eight pins, bit order a0 b0 c0 d0 a1 b1 c1 d1
   input  wire  logic [7:0]  timer_wave,
   // mode outputs to the counter logic
   output logic              sync_run,
   output logic [3:0]        buffer_enable,
   output logic [3:0]        buffer_xfer,
   output logic [3:0]        mode_onehot,
   // pin muxing: 1 hands the pin to the timer
   output logic [7:0]        timer_owns_pin,
   // forced cutoff trigger and pins a0, b0 (oe low drives)
   input  wire  logic        cutoff_req,
   output logic [1:0]        pin_out,
   output logic [1:0]        pin_oe_n
);
   dcp_pkg::dcp_state_s st_r;
   dcp_pkg::dcp_state_s st_nxt;
   dcp_pkg::dcp_mode_e  mode;
   logic                wr_en;
   logic                rd_en;
   logic                addr_ok;
   logic                xfer_evt;
   logic [1:0]          cut_a0;
   logic [1:0]          cut_b0;

   assign wr_en   = psel && penable && pwrite && pstrb[0] && clk_en;
   assign rd_en   = psel && !penable && !pwrite && clk_en;
   assign addr_ok = paddr == `DCP_OFS_BUF_MODE || paddr == `DCP_OFS_FUNC_CTRL ||
                    paddr == `DCP_OFS_CUTOFF_SEL || paddr == `DCP_OFS_OUT_DISABLE ||
                    paddr == `DCP_OFS_STATUS;

   // mode decode: pwm_three_select select only counts when combination is 00
   always_comb begin
      unique case (st_r.func_ctrl[1:0])
         2'h0: mode = st_r.func_ctrl[`DCP_BIT_PWM_THREE_SELECT] ? dcp_pkg::DCP_MODE_TIMER
                                                    : dcp_pkg::DCP_MODE_PWM_THREE_SELECT;
         2'h1: mode = dcp_pkg::DCP_MODE_RSYNC;
         2'h2: mode = dcp_pkg::DCP_MODE_COMPL;
         2'h3: mode = dcp_pkg::DCP_MODE_COMPL;
      endcase
   end

   // transfer event picks underflow or grp0 a match in complementary modes
   always_comb begin
      if (st_r.func_ctrl[1:0] == 2'h2) begin
         xfer_evt = cnt1_underflow;
      end else if (st_r.func_ctrl[1:0] == 2'h3) begin
         xfer_evt = cnt0_match_a;
      end else begin
         xfer_evt = cnt0_match_a;
      end
   end

   assign cut_a0 = st_r.cutoff_sel[`DCP_BIT_A0_CUT_LO +: 2];
   assign cut_b0 = st_r.cutoff_sel[`DCP_BIT_B0_CUT_LO +: 2];

   always_comb begin
      st_nxt = st_r;
      // apb writes, only byte lane 0 carries data
      if (wr_en) begin
         unique case (paddr)
            `DCP_OFS_BUF_MODE:    st_nxt.buf_mode    = pwdata[7:0] & `DCP_BUF_MODE_MASK;
            `DCP_OFS_FUNC_CTRL:   st_nxt.func_ctrl   = pwdata[7:0] & `DCP_FUNC_CTRL_MASK;
            `DCP_OFS_CUTOFF_SEL:  st_nxt.cutoff_sel  = pwdata[7:0];
            `DCP_OFS_OUT_DISABLE: st_nxt.out_disable = pwdata[7:0];
            default: ;
         endcase
      end
      // read data captured in setup so the access phase is zero wait
      if (rd_en) begin
         unique case (paddr)
            `DCP_OFS_BUF_MODE:    st_nxt.prdata = {24'h000000, st_r.buf_mode};
            `DCP_OFS_FUNC_CTRL:   st_nxt.prdata = {24'h000000, st_r.func_ctrl};
            `DCP_OFS_CUTOFF_SEL:  st_nxt.prdata = {24'h000000, st_r.cutoff_sel};
            `DCP_OFS_OUT_DISABLE: st_nxt.prdata = {24'h000000, st_r.out_disable};
            `DCP_OFS_STATUS:      st_nxt.prdata = {27'h0000000, cnt_running, mode};
            default:              st_nxt.prdata = 32'h00000000;
         endcase
      end
      // buffer-to-general transfer pulses, only for groups in buffer role
      st_nxt.xfer_grp = 4'h0;
      if (clk_en && xfer_evt) begin
         st_nxt.xfer_grp = {st_r.buf_mode[`DCP_BIT_GRP1_D], st_r.buf_mode[`DCP_BIT_GRP1_C],
                            st_r.buf_mode[`DCP_BIT_GRP0_D], st_r.buf_mode[`DCP_BIT_GRP0_C]};
      end
      // forced cutoff on a0 and b0; 00 lets the timer wave through
      st_nxt.pin_val  = timer_wave[1:0];
      st_nxt.pin_oe_n = st_r.out_disable[1:0];
      if (cutoff_req && cut_a0 != dcp_pkg::DCP_CUT_OFF) begin
         st_nxt.pin_val[0]  = cut_a0 == dcp_pkg::DCP_CUT_HIGH;
         st_nxt.pin_oe_n[0] = cut_a0 == dcp_pkg::DCP_CUT_HIZ || st_r.out_disable[0];
      end
      if (cutoff_req && cut_b0 != dcp_pkg::DCP_CUT_OFF) begin
         st_nxt.pin_val[1]  = cut_b0 == dcp_pkg::DCP_CUT_HIGH;
         st_nxt.pin_oe_n[1] = cut_b0 == dcp_pkg::DCP_CUT_HIZ || st_r.out_disable[1];
      end
      // clock enable low freezes everything
      if (!clk_en) begin
         st_nxt = st_r;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r.buf_mode    <= `DCP_RST_BUF_MODE;
         st_r.func_ctrl   <= `DCP_RST_FUNC_CTRL;
         st_r.cutoff_sel  <= `DCP_RST_CUTOFF_SEL;
         st_r.out_disable <= `DCP_RST_OUT_DISABLE;
         st_r.prdata      <= 32'h00000000;
         st_r.xfer_grp    <= 4'h0;
         st_r.pin_val     <= 2'h0;
         st_r.pin_oe_n    <= 2'h3;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pready        = 1'b1;
   assign pslverr       = psel && penable && !addr_ok;
   assign prdata        = st_r.prdata;
   assign sync_run      = st_r.buf_mode[`DCP_BIT_SYNC];
   assign buffer_enable = {st_r.buf_mode[`DCP_BIT_GRP1_D],
                           st_r.buf_mode[`DCP_BIT_GRP1_C],
                           st_r.buf_mode[`DCP_BIT_GRP0_D],
                           st_r.buf_mode[`DCP_BIT_GRP0_C]};
   assign buffer_xfer   = st_r.xfer_grp;
   assign mode_onehot   = mode;
   // pin goes to port logic when its disable bit is set
   assign timer_owns_pin = ~st_r.out_disable;
   assign pin_out       = st_r.pin_val;
   assign pin_oe_n      = st_r.pin_oe_n;
endmodule
`default_nettype wire

/* verification/dcp_load.sv */
// external loads on pins a0 and b0
// assumes no pull on the pads, so a released pad wanders
`timescale 1ns/100ps
`default_nettype none
module dcp_load (
   // clock and pin drive
   input wire logic       clk_sys,
   input wire logic [1:0] pin_out, pin_oe_n,
   // level at each pad
   output logic [1:0]     pad
);
   logic [1:0] wander = 2'h1;
   always @(posedge clk_sys) wander <= ~wander;
   assign pad = (pin_out & ~pin_oe_n) | (wander & pin_oe_n);
endmodule
`default_nettype wire

/* verification/dcp_pwm_mode_cfg_assertions.sv */
// assertion checker of the pwm mode block
// assumes bind onto dcp_pwm_mode_cfg, one clock domain
`timescale 1ns/100ps
`default_nettype none
module dcp_chk (
   // clock, reset, apb
   input wire logic        clk_sys, rst_n, clk_en, psel, penable, pwrite, pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb, buffer_enable, buffer_xfer, mode_onehot,
   // events, mode and pins
   input wire logic        cnt1_underflow, cnt0_match_a, cutoff_req, sync_run,
   input wire logic [7:0]  timer_wave, timer_owns_pin,
   input wire logic [1:0]  pin_out, pin_oe_n
);
   wire logic wr = psel && penable && pwrite && pstrb[0] && clk_en;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sync_bit_a: assert property (wr && paddr == 12'h000 |=> sync_run == $past(pwdata[0]))
      else $error("sync bit");
   buf_sel_a: assert property (wr && paddr == 12'h000 |=> buffer_enable == $past(pwdata[7:4]))
      else $error("buffer select");
   pin_own_a: assert property (wr && paddr == 12'h00c |=> timer_owns_pin == ~$past(pwdata[7:0]))
      else $error("pin owner");
   xfer_cause_a: assert property (buffer_xfer != 4'h0 |-> $past(cnt1_underflow || cnt0_match_a)
      && (buffer_xfer & ~$past(buffer_enable)) == 4'h0) else $error("xfer cause");
   mode_one_a: assert property ($onehot(mode_onehot)) else $error("mode code");
   pin_rel_a: assert property (!timer_owns_pin[1] && $past(!timer_owns_pin[1]) |-> pin_oe_n[1])
      else $error("pin release");
   wave_pass_a: assert property ((!cutoff_req && timer_owns_pin[0] && clk_en)[*2]
      |-> !pin_oe_n[0] && pin_out[0] == $past(timer_wave[0])) else $error("wave pass");
   bad_addr_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
      else $error("unmapped");
endmodule
bind dcp_pwm_mode_cfg dcp_chk chk_u (.*);
`default_nettype wire

/* verification/dcp_pwm_mode_cfg_tb.sv */
// self-checking bench of the pwm mode block
// assumes a zero-wait apb slave on one 250 MHz clock
`timescale 1ns/100ps
`default_nettype none
module dcp_pwm_mode_cfg_tb;
   logic clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, cnt1_underflow = 1'b0, cnt0_match_a = 1'b0, cnt_running = 1'b0;
   logic cutoff_req = 1'b0, pready, pslverr, sync_run, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0] timer_wave = 8'h02, timer_owns_pin;
   logic [3:0] pstrb = 4'h1, buffer_enable, buffer_xfer, mode_onehot, seen;
   logic [1:0] pin_out, pin_oe_n, pad;
   logic [7:0] rst_v [4] = '{8'h00, 8'h80, 8'h00, 8'hff};
   logic [7:0] msk_v [4] = '{8'hf1, 8'hcf, 8'hff, 8'hff};
   logic [3:0] mexp [8] = '{4'h2, 4'h1, 4'h4, 4'h4, 4'h8, 4'h8, 4'h8, 4'h8};
   int mismatches = 0, compares = 0;
   initial forever #2 clk_sys = ~clk_sys;
   dcp_pwm_mode_cfg dut_u (.*);
   dcp_load load_u (.*);
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("BAD t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   // setup edge, then access held until pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd, e);
   endtask
   // one event pulse, then gather the transfer strobes
   task automatic xfer(input logic [1:0] c, input logic u, input logic [3:0] e);
      apb(1'b1, 12'h004, {30'h0, c});
      @(posedge clk_sys);
      cnt1_underflow <= u;
      cnt0_match_a <= !u;
      @(posedge clk_sys);
      cnt1_underflow <= 1'b0;
      cnt0_match_a <= 1'b0;
      seen = 4'h0;
      repeat (3) begin
         #1 seen |= buffer_xfer;
         @(posedge clk_sys);
      end
      check(seen, e);
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rdc(12'(4 * i), {24'h0, rst_v[i]});
         apb(1'b1, 12'(4 * i), 32'hffff_ffff);
         rdc(12'(4 * i), {24'h0, msk_v[i]});
      end
      check({sync_run, buffer_enable}, 32'h1f);
      rdc(12'h020, 32'h0);
      check(err, 1'b1);
      cnt_running <= 1'b1;
      apb(1'b1, 12'h010, 32'hff);
      rdc(12'h010, 32'h18);
      $display("test registers done");
      for (int m = 0; m < 8; m++) begin
         apb(1'b1, 12'h004, {24'h0, m[0], 5'h0, m[2:1]});
         check(mode_onehot, mexp[m]);
      end
      $display("test modes done");
      apb(1'b1, 12'h000, 32'h50);
      check(sync_run, 1'b0);
      xfer(2'h2, 1'b1, 4'h5);
      xfer(2'h2, 1'b0, 4'h0);
      xfer(2'h3, 1'b0, 4'h5);
      xfer(2'h3, 1'b1, 4'h0);
      apb(1'b1, 12'h000, 32'ha0);
      xfer(2'h3, 1'b0, 4'ha);
      $display("test transfers done");
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b1, 12'h00c, 32'hfc);
      repeat (2) @(posedge clk_sys);
      #1 check({timer_owns_pin, pad}, {8'h03, 2'h2});
      @(posedge clk_sys);
      cutoff_req <= 1'b1;
      for (int c = 1; c < 4; c++) begin
         apb(1'b1, 12'h008, {24'h0, c[1:0], c[1:0], 4'h0});
         repeat (2) @(posedge clk_sys);
         #1 check(c == 1 ? pin_oe_n : {pin_oe_n, pad}, c == 1 ? 4'h3 : {2'h0, c[0], c[0]});
      end
      apb(1'b1, 12'h008, 32'h0);
      repeat (2) @(posedge clk_sys);
      #1 check(pad, 2'h2);
      apb(1'b1, 12'h00c, 32'hff);
      repeat (2) @(posedge clk_sys);
      #1 check(pin_oe_n, 2'h3);
      $display("test pins done");
      finish_test;
   end
   initial begin
      #40000;
      mismatches++;
      finish_test;
   end
endmodule
`default_nettype wire
